// ---- design/oslf_consts.svh ----
// Constants for the output scale, limit and frequency command bank
`ifndef OSLF_CONSTS_SVH
`define OSLF_CONSTS_SVH
`define OSLF_CMD_SCALE 8'h29
`define OSLF_CMD_FLOOR 8'h2b
`define OSLF_CMD_FREQ 8'h33
`define OSLF_CMD_VINON 8'h35
`define OSLF_SCALE_EXP_RST 5'h19
`define OSLF_VINON_EXP 5'h1e
`define OSLF_FIX_FRAC 16
`define OSLF_DIV_EDGE0 48'h0000_0000_2000
`define OSLF_DIV_EDGE1 48'h0000_0000_4000
`define OSLF_DIV_EDGE2 48'h0000_0000_8000
`define OSLF_SCALE_MAX 48'h0000_0001_0000
`define OSLF_FREQ_LIMIT 11'h672
`define OSLF_FREQ_EXP_ONE 5'h01
`define OSLF_MAN_MAX 11'h3ff
`define OSLF_VINON_CODE_MIN 6'h0a
`define OSLF_FLOOR_VALID_LO 16'h0000
`define OSLF_FLOOR_VALID_HI 16'h5800
`endif

// ---- design/oslf_pkg.sv ----
// Types for the output scale, limit and frequency command bank
package oslf_pkg;
    typedef enum logic [1:0] {
        OSLF_DIV_EIGHTH,
        OSLF_DIV_QUARTER,
        OSLF_DIV_HALF,
        OSLF_DIV_FULL
    } oslf_div_t;

    typedef struct packed {
        logic [15:0] scale_r;
        logic [15:0] floor_r;
        logic [15:0] freq_r;
        logic [15:0] vinon_r;
        logic [15:0] scale_hw_r;
        logic [15:0] freq_hw_r;
        oslf_div_t div_r;
        logic [3:0] fsel_r;
        logic [5:0] vinon_code_r;
        logic [15:0] target_r;
        logic clamp_r;
        logic [15:0] rd_data_r;
        logic rd_valid_r;
        logic invalid_r;
        logic warn_r;
    } oslf_state_t;
endpackage : oslf_pkg

// ---- design/oslf_regs.sv ----
// Command word bank: feedback scale, output floor, switching rate, turn-on threshold
`timescale 1ns/1ns
`include "oslf_consts.svh"
module oslf_regs
    import oslf_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] cmd_code,
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    input wire logic rd_en,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic invalid_data,
    input wire logic nvm_restore,
    input wire logic [10:0] nvm_scale_man,
    input wire logic [15:0] nvm_floor,
    input wire logic [10:0] nvm_freq_khz,
    input wire logic [10:0] nvm_vinon_man,
    input wire logic conv_en,
    input wire logic analog_supply_uvlo,
    input wire logic [15:0] vout_request,
    input wire logic [15:0] vout_ceiling,
    output logic [15:0] scale_applied,
    output oslf_div_t div_select,
    output logic [3:0] freq_select,
    output logic [10:0] freq_eff_khz,
    output logic [5:0] vinon_code,
    output logic [15:0] vout_target,
    output logic status_none_above,
    output logic status_vout,
    output logic status_vout_minmax,
    output logic host_alert
);

    // ****************************************
    // Linear decode
    // ****************************************
    // Fixed point with 16 fraction bits; 48 bits hold any 11-bit mantissa shifted
    function automatic logic signed [47:0] lin_fix(input logic [15:0] w);
        logic [5:0] sh;
        logic signed [47:0] m;
        sh = 6'(signed'({w[15], w[15:11]}) + 6'sd16);
        m = 48'(signed'(w[10:0]));
        lin_fix = m <<< sh;
    endfunction : lin_fix

    function automatic logic [47:0] khz_fix(input logic [10:0] k);
        khz_fix = {21'h0, k, 16'h0};
    endfunction : khz_fix

    // ****************************************
    // Tables
    // ****************************************
    localparam logic [10:0] FREQ_EDGE [0:10] = '{
        11'h0fa, 11'h12c, 11'h15e, 11'h19a, 11'h1f4, 11'h258,
        11'h2bc, 11'h334, 11'h3e8, 11'h4b0, 11'h578
    };
    localparam logic [10:0] FREQ_EFF [0:11] = '{
        11'h0e1, 11'h113, 11'h145, 11'h177, 11'h1c2, 11'h226,
        11'h28a, 11'h2ee, 11'h384, 11'h44c, 11'h514, 11'h5dc
    };

    oslf_state_t st_r;
    oslf_state_t st_nxt;

    logic signed [47:0] wr_fix;
    logic signed [47:0] scale_fix;
    logic signed [47:0] freq_fix;
    logic signed [47:0] vinon_fix;
    logic wr_ok;
    logic hit_scale;
    logic hit_floor;
    logic hit_freq;
    logic hit_vinon;
    logic hw_update;
    logic [15:0] nvm_freq_word;
    logic [15:0] goal;
    logic clamp_now;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.rd_valid_r = 1'b0;
        st_nxt.invalid_r = 1'b0;
        st_nxt.warn_r = 1'b0;

        hit_scale = cmd_code == `OSLF_CMD_SCALE;
        hit_floor = cmd_code == `OSLF_CMD_FLOOR;
        hit_freq = cmd_code == `OSLF_CMD_FREQ;
        hit_vinon = cmd_code == `OSLF_CMD_VINON;
        wr_fix = lin_fix(wr_data);

        // Validity of the written word per command
        wr_ok = 1'b1;
        if (hit_scale) begin
            wr_ok = wr_fix > 0 && wr_fix <= $signed(`OSLF_SCALE_MAX);
        end else if (hit_floor) begin
            wr_ok = wr_data >= `OSLF_FLOOR_VALID_LO && wr_data <= `OSLF_FLOOR_VALID_HI;
        end else if (hit_freq) begin
            wr_ok = wr_fix > 0 && wr_fix < $signed(khz_fix(`OSLF_FREQ_LIMIT));
        end else if (hit_vinon) begin
            wr_ok = (wr_fix >>> 14) >= $signed(48'(`OSLF_VINON_CODE_MIN))
                && (wr_fix >>> 14) <= 48'sd63;
        end

        if (wr_en) begin
            if (!wr_ok && (hit_scale || hit_floor || hit_freq || hit_vinon)) begin
                st_nxt.invalid_r = 1'b1;
            end else if (hit_scale) begin
                st_nxt.scale_r = wr_data;
            end else if (hit_floor) begin
                st_nxt.floor_r = wr_data;
            end else if (hit_freq) begin
                st_nxt.freq_r = wr_data;
            end else if (hit_vinon) begin
                st_nxt.vinon_r = wr_data;
            end
        end

        // Exponent auto-generated so the stored kHz figure fits the mantissa
        if (nvm_freq_khz > `OSLF_MAN_MAX) begin
            nvm_freq_word = {`OSLF_FREQ_EXP_ONE, 1'b0, nvm_freq_khz[10:1]};
        end else begin
            nvm_freq_word = {5'h00, nvm_freq_khz};
        end

        if (nvm_restore) begin
            st_nxt.scale_r = {`OSLF_SCALE_EXP_RST, nvm_scale_man};
            st_nxt.floor_r = nvm_floor;
            st_nxt.freq_r = nvm_freq_word;
            st_nxt.vinon_r = {`OSLF_VINON_EXP, nvm_vinon_man};
        end

        // Hardware copies follow writes while conversion is off, during NVM restore or during analog supply UVLO
        hw_update = !conv_en || nvm_restore || analog_supply_uvlo;
        if (hw_update) begin
            st_nxt.scale_hw_r = st_nxt.scale_r;
            st_nxt.freq_hw_r = st_nxt.freq_r;
        end

        // Divider ratio from the applied scale
        scale_fix = lin_fix(st_r.scale_hw_r);
        if (scale_fix <= $signed(`OSLF_DIV_EDGE0)) begin
            st_nxt.div_r = OSLF_DIV_EIGHTH;
        end else if (scale_fix <= $signed(`OSLF_DIV_EDGE1)) begin
            st_nxt.div_r = OSLF_DIV_QUARTER;
        end else if (scale_fix <= $signed(`OSLF_DIV_EDGE2)) begin
            st_nxt.div_r = OSLF_DIV_HALF;
        end else begin
            st_nxt.div_r = OSLF_DIV_FULL;
        end

        // Frequency bin: count the edges at or below the request
        freq_fix = lin_fix(st_r.freq_hw_r);
        st_nxt.fsel_r = 4'h0;
        for (int i = 0; i < 11; i++) begin
            if (freq_fix >= $signed(khz_fix(FREQ_EDGE[i]))) begin
                st_nxt.fsel_r = 4'(i + 1);
            end
        end

        // Quarter-volt code, rounded down and held inside the hardware span
        vinon_fix = lin_fix(st_r.vinon_r) >>> 14;
        if (vinon_fix < $signed(48'(`OSLF_VINON_CODE_MIN))) begin
            st_nxt.vinon_code_r = `OSLF_VINON_CODE_MIN;
        end else if (vinon_fix > 48'sd63) begin
            st_nxt.vinon_code_r = 6'h3f;
        end else begin
            st_nxt.vinon_code_r = vinon_fix[5:0];
        end

        // Output window: limit changes are caught by the same compare
        goal = vout_request;
        clamp_now = 1'b0;
        if (conv_en && vout_request < st_r.floor_r) begin
            goal = st_r.floor_r;
            clamp_now = 1'b1;
        end else if (conv_en && vout_request > vout_ceiling) begin
            goal = vout_ceiling;
            clamp_now = 1'b1;
        end
        st_nxt.target_r = goal;
        st_nxt.clamp_r = clamp_now;
        st_nxt.warn_r = clamp_now && !st_r.clamp_r;

        if (rd_en) begin
            st_nxt.rd_valid_r = 1'b1;
            unique case (1'b1)
                hit_scale: st_nxt.rd_data_r = st_r.scale_r;
                hit_floor: st_nxt.rd_data_r = st_r.floor_r;
                hit_freq: st_nxt.rd_data_r = st_r.freq_r;
                hit_vinon: st_nxt.rd_data_r = st_r.vinon_r;
                default: st_nxt.rd_data_r = 16'h0000;
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    // Mantissas are zero until the NVM restore pulse loads them
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
            st_r.scale_r <= {`OSLF_SCALE_EXP_RST, 11'h000};
            st_r.scale_hw_r <= {`OSLF_SCALE_EXP_RST, 11'h000};
            st_r.vinon_r <= {`OSLF_VINON_EXP, 11'h000};
            st_r.vinon_code_r <= `OSLF_VINON_CODE_MIN;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign rd_data = st_r.rd_data_r;
    assign rd_valid = st_r.rd_valid_r;
    assign invalid_data = st_r.invalid_r;
    assign scale_applied = st_r.scale_hw_r;
    assign div_select = st_r.div_r;
    assign freq_select = st_r.fsel_r;
    assign freq_eff_khz = FREQ_EFF[st_r.fsel_r];
    assign vinon_code = st_r.vinon_code_r;
    assign vout_target = st_r.target_r;
    assign status_none_above = st_r.warn_r || st_r.invalid_r;
    assign status_vout = st_r.warn_r;
    assign status_vout_minmax = st_r.warn_r;
    assign host_alert = st_r.warn_r || st_r.invalid_r;

    // ****************************************
    // Checks
    // ****************************************
    a_bad_write_flag: assert property (@(posedge clk) disable iff (!resetn)
        wr_en && hit_freq && wr_data == 16'h0000 |=> invalid_data && host_alert)
        else $error("Invalid write not flagged");

    a_scale_held: assert property (@(posedge clk) disable iff (!resetn)
        conv_en && !nvm_restore && !analog_supply_uvlo |=> $stable(scale_applied))
        else $error("Scale changed while converting");

    a_scale_idle: assert property (@(posedge clk) disable iff (!resetn)
        !conv_en && wr_en && hit_scale && wr_ok && !nvm_restore
        |=> scale_applied == $past(wr_data))
        else $error("Idle scale write not applied");

    a_floor_clamp: assert property (@(posedge clk) disable iff (!resetn)
        conv_en && vout_request < st_r.floor_r |=> vout_target == $past(st_r.floor_r))
        else $error("Target not clamped to floor");

    a_warn_once: assert property (@(posedge clk) disable iff (!resetn)
        status_vout_minmax |=> !status_vout_minmax)
        else $error("Warning pulse longer than one cycle");

    a_warn_cause: assert property (@(posedge clk) disable iff (!resetn)
        !st_r.clamp_r && conv_en && (vout_request < st_r.floor_r || vout_request > vout_ceiling)
        |=> status_vout && host_alert)
        else $error("Window breach not reported");

    a_read_back: assert property (@(posedge clk) disable iff (!resetn)
        rd_en && hit_scale && !wr_en |=> rd_valid && rd_data == $past(st_r.scale_r))
        else $error("Scale read back wrong");

    a_vinon_span: assert property (@(posedge clk) disable iff (!resetn)
        vinon_code >= `OSLF_VINON_CODE_MIN)
        else $error("Turn-on code below span");

    a_restore_exp: assert property (@(posedge clk) disable iff (!resetn)
        nvm_restore ##1 !(rd_en || wr_en) [*1] ##0 1'b1
        |-> st_r.scale_r[15:11] == `OSLF_SCALE_EXP_RST)
        else $error("Restored scale exponent wrong");

    a_div_eighth: assert property (@(posedge clk) disable iff (!resetn)
        scale_fix <= $signed(`OSLF_DIV_EDGE0)
        |=> div_select == OSLF_DIV_EIGHTH)
        else $error("Small scale not mapped to eighth divider");

    a_div_full: assert property (@(posedge clk) disable iff (!resetn)
        scale_fix > $signed(`OSLF_DIV_EDGE2)
        |=> div_select == OSLF_DIV_FULL)
        else $error("Large scale not mapped to full divider");

    a_freq_low_bin: assert property (@(posedge clk) disable iff (!resetn)
        freq_fix < $signed(khz_fix(FREQ_EDGE[0]))
        |=> freq_eff_khz == FREQ_EFF[0])
        else $error("Low request not in lowest bin");

    a_freq_top_bin: assert property (@(posedge clk) disable iff (!resetn)
        freq_fix >= $signed(khz_fix(FREQ_EDGE[10]))
        |=> freq_select == 4'hb)
        else $error("High request not in top bin");

    a_freq_held: assert property (@(posedge clk) disable iff (!resetn)
        conv_en && !nvm_restore && !analog_supply_uvlo
        |=> $stable(st_r.freq_hw_r))
        else $error("Frequency changed while converting");

    a_freq_idle: assert property (@(posedge clk) disable iff (!resetn)
        !conv_en && wr_en && hit_freq && wr_ok && !nvm_restore
        |=> st_r.freq_hw_r == $past(wr_data))
        else $error("Idle frequency write not applied");

    a_floor_write: assert property (@(posedge clk) disable iff (!resetn)
        wr_en && hit_floor && wr_ok && !nvm_restore
        |=> st_r.floor_r == $past(wr_data))
        else $error("Floor write not stored");

    a_floor_range: assert property (@(posedge clk) disable iff (!resetn)
        wr_en && hit_floor && wr_data > `OSLF_FLOOR_VALID_HI && !nvm_restore
        |=> invalid_data && $stable(st_r.floor_r))
        else $error("Out of range floor accepted");

    a_vinon_fly: assert property (@(posedge clk) disable iff (!resetn)
        wr_en && hit_vinon && wr_ok && !nvm_restore
        |=> st_r.vinon_r == $past(wr_data))
        else $error("Turn-on write not stored");

    a_read_other: assert property (@(posedge clk) disable iff (!resetn)
        rd_en && !(hit_scale || hit_floor || hit_freq || hit_vinon)
        |=> rd_valid && rd_data == 16'h0000)
        else $error("Unknown code read not zero");

    a_status_same: assert property (@(posedge clk) disable iff (!resetn)
        status_vout
        |-> status_vout_minmax && status_none_above && host_alert)
        else $error("Clamp status bits split");

    a_no_clamp_idle: assert property (@(posedge clk) disable iff (!resetn)
        !conv_en
        |=> vout_target == $past(vout_request) && !status_vout)
        else $error("Clamp active while not converting");

    a_restore_freq: assert property (@(posedge clk) disable iff (!resetn)
        nvm_restore && nvm_freq_khz <= `OSLF_MAN_MAX
        |=> st_r.freq_r == {5'h00, $past(nvm_freq_khz)})
        else $error("Restored frequency word wrong");

    a_scale_invalid: assert property (@(posedge clk) disable iff (!resetn)
        wr_en && hit_scale && !wr_ok
        |=> invalid_data && host_alert && status_none_above)
        else $error("Invalid scale write not flagged");

endmodule : oslf_regs

// ---- testbench/oslf_host.sv ----
// Host controller model issuing word reads and writes to the command bank
`timescale 1ns/1ns
`include "oslf_consts.svh"
module oslf_host (
    input wire logic clk,
    output logic [7:0] cmd_code,
    output logic wr_en,
    output logic [15:0] wr_data,
    output logic rd_en,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid
);
    initial begin
        cmd_code = 8'h00;
        wr_en = 1'b0;
        wr_data = 16'h0000;
        rd_en = 1'b0;
    end

    task automatic write_word(input logic [7:0] code, input logic [15:0] word);
        // Fast rates need an outside five volt rail, so this host drops exponent-zero frequency words above 1100 kHz
        if (code == `OSLF_CMD_FREQ && word[15:11] == 5'h00 && word[10:0] > 11'd1100) begin
            return;
        end
        @(posedge clk);
        #1;
        cmd_code = code;
        wr_data = word;
        wr_en = 1'b1;
        @(posedge clk);
        #1;
        wr_en = 1'b0;
        // Idle lines show the inverse so a stale value cannot pass for a new one
        cmd_code = ~cmd_code;
        wr_data = ~wr_data;
    endtask : write_word

    task automatic read_word(input logic [7:0] code, output logic [15:0] word, output logic ok);
        @(posedge clk);
        #1;
        cmd_code = code;
        rd_en = 1'b1;
        @(posedge clk);
        #1;
        rd_en = 1'b0;
        cmd_code = ~cmd_code;
        word = rd_data;
        ok = rd_valid;
    endtask : read_word
endmodule : oslf_host

// ---- testbench/output_scale_limit_freq_cmds_bench.sv ----
// Self-checking bench for the command word bank
`timescale 1ns/1ns
`include "oslf_consts.svh"
module output_scale_limit_freq_cmds_bench
    import oslf_pkg::*;
;
    logic clk = 1'b0;
    logic resetn, wr_en, rd_en, rd_valid, invalid_data, nvm_restore, conv_en;
    logic analog_supply_uvlo, status_none_above, status_vout, status_vout_minmax, host_alert;
    logic [7:0] cmd_code;
    logic [15:0] wr_data, rd_data, nvm_floor, vout_request, vout_ceiling, scale_applied;
    logic [15:0] vout_target;
    logic [10:0] nvm_scale_man, nvm_freq_khz, nvm_vinon_man, freq_eff_khz;
    logic [3:0] freq_select;
    logic [5:0] vinon_code;
    oslf_div_t div_select;
    int mismatches = 0;
    int n_checks = 0;

    always #5 clk = ~clk;

    oslf_host host (.clk, .cmd_code, .wr_en, .wr_data, .rd_en, .rd_data, .rd_valid);

    oslf_regs dut (.clk, .resetn, .cmd_code, .wr_en, .wr_data, .rd_en, .rd_data, .rd_valid,
        .invalid_data, .nvm_restore, .nvm_scale_man, .nvm_floor, .nvm_freq_khz,
        .nvm_vinon_man, .conv_en, .analog_supply_uvlo, .vout_request, .vout_ceiling,
        .scale_applied, .div_select, .freq_select, .freq_eff_khz, .vinon_code,
        .vout_target, .status_none_above, .status_vout, .status_vout_minmax, .host_alert);

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic rd(input logic [7:0] code, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        host.read_word(code, d, ok);
        check({15'h0000, ok}, 16'h0001);
        check(d, exp);
    endtask : rd

    task automatic restore();
        nvm_restore = 1'b1;
        step(1);
        nvm_restore = 1'b0;
        step(3);
    endtask : restore

    task automatic t_reset();
        rd(`OSLF_CMD_SCALE, 16'hc800);
        check({10'h000, vinon_code}, 16'h000a);
        $display("test reset done");
    endtask : t_reset

    task automatic t_restore();
        nvm_scale_man = 11'h040;
        nvm_floor = 16'h1000;
        nvm_freq_khz = 11'h1f4;
        nvm_vinon_man = 11'h015;
        restore();
        rd(`OSLF_CMD_SCALE, 16'hc840);
        rd(`OSLF_CMD_FREQ, 16'h01f4);
        rd(`OSLF_CMD_VINON, 16'hf015);
        rd(`OSLF_CMD_FLOOR, 16'h1000);
        check({14'h0000, div_select}, 16'h0002);
        check({5'h00, freq_eff_khz}, 16'd550);
        check({10'h000, vinon_code}, 16'd21);
        $display("test restore done");
    endtask : t_restore

    task automatic t_scale();
        int man[7] = '{16, 17, 32, 33, 64, 65, 128};
        int dv[7] = '{0, 1, 1, 2, 2, 3, 3};
        for (int i = 0; i < 7; i++) begin
            host.write_word(`OSLF_CMD_SCALE, 16'hc800 | 16'(man[i]));
            step(3);
            rd(`OSLF_CMD_SCALE, 16'hc800 | 16'(man[i]));
            check(scale_applied, 16'hc800 | 16'(man[i]));
            check({14'h0000, div_select}, 16'(dv[i]));
        end
        $display("test scale done");
    endtask : t_scale

    task automatic t_freq();
        int f[10] = '{249, 250, 299, 300, 409, 410, 819, 820, 999, 1000};
        int eff[10] = '{225, 275, 275, 325, 375, 450, 750, 900, 900, 1100};
        int sel[10] = '{0, 1, 1, 2, 3, 4, 7, 8, 8, 9};
        for (int i = 0; i < 10; i++) begin
            host.write_word(`OSLF_CMD_FREQ, 16'(f[i]));
            step(3);
            check({5'h00, freq_eff_khz}, 16'(eff[i]));
            check({12'h000, freq_select}, 16'(sel[i]));
        end
        $display("test freq done");
    endtask : t_freq

    task automatic t_invalid();
        logic [7:0] code[9] = '{8'h29, 8'h33, 8'h2b, 8'h2b, 8'h35, 8'h35, 8'h35, 8'h35, 8'h30};
        logic [15:0] word[9] = '{16'hc881, 16'h0000, 16'h5801, 16'h5800, 16'hf040,
            16'hf009, 16'hf7f6, 16'hf00a, 16'h1234};
        logic bad[9] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 9; i++) begin
            host.write_word(code[i], word[i]);
            check({15'h0000, invalid_data}, {15'h0000, bad[i]});
            check({15'h0000, host_alert}, {15'h0000, bad[i]});
            check({15'h0000, status_none_above}, {15'h0000, bad[i]});
        end
        rd(`OSLF_CMD_SCALE, 16'hc880);
        rd(`OSLF_CMD_FLOOR, 16'h5800);
        rd(8'h30, 16'h0000);
        $display("test invalid done");
    endtask : t_invalid

    task automatic t_block();
        conv_en = 1'b1;
        host.write_word(`OSLF_CMD_FREQ, 16'h01c2);
        host.write_word(`OSLF_CMD_SCALE, 16'hc810);
        step(3);
        check({5'h00, freq_eff_khz}, 16'd1100);
        check({14'h0000, div_select}, 16'h0003);
        rd(`OSLF_CMD_FREQ, 16'h01c2);
        host.write_word(`OSLF_CMD_VINON, 16'he857);
        step(3);
        check({10'h000, vinon_code}, 16'd43);
        analog_supply_uvlo = 1'b1;
        step(1);
        analog_supply_uvlo = 1'b0;
        step(3);
        check({5'h00, freq_eff_khz}, 16'd450);
        check({14'h0000, div_select}, 16'h0000);
        nvm_freq_khz = 11'd1100;
        restore();
        rd(`OSLF_CMD_FREQ, 16'h0a26);
        check({5'h00, freq_eff_khz}, 16'd1100);
        $display("test block done");
    endtask : t_block

    task automatic t_clamp();
        step(2);
        check(vout_target, 16'h2000);
        vout_request = 16'h0800;
        step(1);
        check(vout_target, 16'h1000);
        check({12'h000, status_none_above, status_vout, status_vout_minmax, host_alert},
            16'h000f);
        step(1);
        check({15'h0000, status_vout}, 16'h0000);
        host.write_word(`OSLF_CMD_FLOOR, 16'h0400);
        step(2);
        check(vout_target, 16'h0800);
        vout_request = 16'h2000;
        step(2);
        vout_ceiling = 16'h0c00;
        step(1);
        check(vout_target, 16'h0c00);
        check({15'h0000, status_vout_minmax}, 16'h0001);
        $display("test clamp done");
    endtask : t_clamp

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    initial begin
        resetn = 1'b0;
        nvm_restore = 1'b0;
        nvm_scale_man = 11'h000;
        nvm_floor = 16'h0000;
        nvm_freq_khz = 11'h000;
        nvm_vinon_man = 11'h000;
        conv_en = 1'b0;
        analog_supply_uvlo = 1'b0;
        vout_request = 16'h2000;
        vout_ceiling = 16'h5000;
        repeat (2) @(posedge clk);
        #1;
        resetn = 1'b1;
        t_reset();
        t_restore();
        t_scale();
        t_freq();
        t_invalid();
        t_block();
        t_clamp();
        stop_test();
    end

    // The whole run takes well under a thousand cycles
    initial begin
        #50000;
        mismatches++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule : output_scale_limit_freq_cmds_bench
